// File: io_space_access_decode.v
// Functional notes
// - All registers reachable by data loads, stores
// - Low 32 registers take bit set/clear, except the flag register, which takes bit clear only
// - Low 32 registers support bit skip tests
// - Port instructions use six-bit address only
// - Data address equals port address plus 0x20
// - Extended region reachable by data access only
// - Some flags clear on writing one
// - Bit ops touch only the addressed bit
// - Bit ops act only below 0x20
// - Three plain general-purpose byte registers
// - Storage registers in low range bit-accessible
//
// Decoder for the peripheral register space of a small core.
// Assumes the core presents one access per cycle on ref_clk.
`timescale 1ns/1ps
`include "io_decode_consts.vh"
module io_space_access_decode (
  input wire ref_clk,
  input wire reset,
  input wire acc_valid,
  input wire [1:0] acc_kind,
  input wire acc_write,
  input wire [8:0] acc_addr,
  input wire [7:0] acc_wdata,
  input wire [1:0] bit_op,
  input wire [2:0] bit_sel,
  input wire flag_event,
  input wire [7:0] flag_set,
  input wire [7:0] ext_rdata,
  output reg [7:0] rdata_reg,
  output reg rvalid_reg,
  output reg skip_reg,
  output reg access_err_reg,
  output reg ext_wr_reg,
  output reg [8:0] ext_addr_reg,
  output reg [7:0] ext_wdata_reg,
  output wire [7:0] flags_out
);
  wire [8:0] port_addr; // Address normalised to port numbering
  wire in_port; // Falls in the 64 port locations
  wire in_bit; // Falls in the bit-accessible range
  wire in_ext; // Falls in the extended region
  wire legal; // Access kind may reach this address
  wire [7:0] gs0;
  wire [7:0] gs1;
  wire [7:0] gs2;
  reg [7:0] flag_reg; // Sticky flags, cleared by writing one
  reg [7:0] rd_mux; // Selected read byte
  reg [7:0] flag_next;
  wire is_data;
  wire is_bit;
  wire do_write;
  wire do_bitwr;
  wire bit_val;
  wire wr0;
  wire wr1;
  wire wr2;
  wire hit0;
  wire hit1;
  wire hit2;
  wire hitf;

  assign is_data = (acc_kind == `ACC_DATA);
  assign is_bit = (acc_kind == `ACC_BIT);
  // Data accesses sit 0x20 above port numbering
  assign port_addr = is_data ? (acc_addr - `DATA_OFS) : acc_addr;
  // Data addresses below the offset map to the core's own registers, not here
  assign in_port = is_data ? (acc_addr >= `DATA_OFS && acc_addr < `EXT_FIRST) :
    (acc_addr <= `PORT_LAST);
  assign in_bit = in_port && (port_addr <= `BIT_LAST);
  assign in_ext = is_data && (acc_addr >= `EXT_FIRST) && (acc_addr <= `EXT_LAST);
  // Extended region refused for port and bit forms
  assign legal = is_data ? (in_port || in_ext) :
    (is_bit ? in_bit : in_port);
  assign do_write = acc_valid && legal && acc_write && !is_bit;
  assign do_bitwr = acc_valid && legal && is_bit && (bit_op != `BOP_TEST);
  assign bit_val = (bit_op == `BOP_SET);
  assign hit0 = in_port && (port_addr[5:0] == `GS0_PORT);
  assign hit1 = in_port && (port_addr[5:0] == `GS1_PORT);
  assign hit2 = in_port && (port_addr[5:0] == `GS2_PORT);
  assign hitf = in_port && (port_addr[5:0] == `FLAG_PORT);
  assign wr0 = do_write && hit0;
  assign wr1 = do_write && hit1;
  assign wr2 = do_write && hit2;
  assign flags_out = flag_reg;

  // Three identical storage registers
  byte_store u_gs0 (
    .ref_clk(ref_clk), .reset(reset), .wr_en(wr0), .wr_data(acc_wdata),
    .bit_en(do_bitwr && hit0), .bit_sel(bit_sel), .bit_val(bit_val),
    .value_reg(gs0)
  );
  byte_store u_gs1 (
    .ref_clk(ref_clk), .reset(reset), .wr_en(wr1), .wr_data(acc_wdata),
    .bit_en(do_bitwr && hit1), .bit_sel(bit_sel), .bit_val(bit_val),
    .value_reg(gs1)
  );
  byte_store u_gs2 (
    .ref_clk(ref_clk), .reset(reset), .wr_en(wr2), .wr_data(acc_wdata),
    .bit_en(do_bitwr && hit2), .bit_sel(bit_sel), .bit_val(bit_val),
    .value_reg(gs2)
  );

  // Flag register next value; a new event beats a clear in the same cycle
  always @* begin
    flag_next = flag_reg;
    if (acc_valid && legal && hitf) begin
      if (do_write) begin
        flag_next = flag_reg & ~acc_wdata;
      end else if (do_bitwr && !bit_val) begin
        // Only the addressed bit is cleared; neighbours are never written back
        flag_next[bit_sel] = 1'b0;
      end
    end
    if (flag_event) begin
      flag_next = flag_next | flag_set;
    end
  end

  // Flag register state
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      flag_reg <= `ZERO8;
    end else begin
      flag_reg <= flag_next;
    end
  end

  // Read selection, reads have no side effect
  always @* begin
    if (in_ext) begin
      rd_mux = ext_rdata;
    end else if (hit0) begin
      rd_mux = gs0;
    end else if (hit1) begin
      rd_mux = gs1;
    end else if (hit2) begin
      rd_mux = gs2;
    end else if (hitf) begin
      rd_mux = flag_reg;
    end else begin
      rd_mux = `ZERO8; // Unassigned locations read zero
    end
  end

  // Registered answer: read data, skip result, refusal, extended write
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rdata_reg <= `ZERO8;
      rvalid_reg <= 1'b0;
      skip_reg <= 1'b0;
      access_err_reg <= 1'b0;
      ext_wr_reg <= 1'b0;
      ext_addr_reg <= 9'h000;
      ext_wdata_reg <= `ZERO8;
    end else begin
      rvalid_reg <= acc_valid && legal && !acc_write && !is_bit;
      rdata_reg <= (acc_valid && legal && !acc_write) ? rd_mux : `ZERO8;
      // Skip test reports whether the selected bit of the read byte is set
      skip_reg <= acc_valid && legal && is_bit && (bit_op == `BOP_TEST) &&
        rd_mux[bit_sel];
      access_err_reg <= acc_valid && !legal;
      ext_wr_reg <= acc_valid && in_ext && acc_write;
      ext_addr_reg <= acc_addr;
      ext_wdata_reg <= acc_wdata;
    end
  end
endmodule

// File: io_decode_consts.vh
// Constants for the peripheral register space decoder.
// Assumes inclusion by bare name from the design files.
`ifndef IO_DECODE_CONSTS_VH
`define IO_DECODE_CONSTS_VH
// Access kinds presented by the core
`define ACC_PORT 2'h0
`define ACC_DATA 2'h1
`define ACC_BIT 2'h2
// Bit operations
`define BOP_SET 2'h0
`define BOP_CLR 2'h1
`define BOP_TEST 2'h2
// Port space limits
`define PORT_LAST 9'h03F
`define BIT_LAST 9'h01F
// Offset from port address to data address
`define DATA_OFS 9'h020
// Extended region limits (data addresses)
`define EXT_FIRST 9'h060
`define EXT_LAST 9'h1FF
// Port addresses of the storage registers
`define GS0_PORT 6'h1E
`define GS1_PORT 6'h2A
`define GS2_PORT 6'h2B
// Port address of the sample flag register (write one to clear)
`define FLAG_PORT 6'h15
// Reset value of storage registers
`define GS_RESET 8'h00
`define ZERO8 8'h00
`endif

// File: byte_store.v
// One general-purpose byte register with write and bit update.
// Assumes writes arrive as one-cycle strobes on the core clock.
`timescale 1ns/1ps
`include "io_decode_consts.vh"
module byte_store (
  input wire ref_clk,
  input wire reset,
  input wire wr_en,
  input wire [7:0] wr_data,
  input wire bit_en,
  input wire [2:0] bit_sel,
  input wire bit_val,
  output reg [7:0] value_reg
);
  // Whole-byte or single-bit update, stored at edge end
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      value_reg <= `GS_RESET;
    end else if (wr_en) begin
      value_reg <= wr_data;
    end else if (bit_en) begin
      value_reg[bit_sel] <= bit_val;
    end
  end
endmodule

// File: io_chk_sva.sv
// Port checker for the peripheral space decoder.
// Assumes binding onto io_space_access_decode.
`timescale 1ns/1ps
`include "io_decode_consts.vh"
module io_chk (
  input wire ref_clk,
  input wire reset,
  input wire acc_valid,
  input wire [1:0] acc_kind,
  input wire acc_write,
  input wire [8:0] acc_addr,
  input wire [7:0] acc_wdata,
  input wire [1:0] bit_op,
  input wire [2:0] bit_sel,
  input wire flag_event,
  input wire rvalid_reg,
  input wire skip_reg,
  input wire access_err_reg,
  input wire ext_wr_reg,
  input wire [8:0] ext_addr_reg,
  input wire [7:0] ext_wdata_reg,
  input wire [7:0] flags_out
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Access kind decodes
  wire pv = acc_valid && acc_kind == `ACC_PORT;
  wire dv = acc_valid && acc_kind == `ACC_DATA;
  wire bv = acc_valid && acc_kind == `ACC_BIT;
  wire ds = dv && acc_write;
  wire bt = bv && bit_op == `BOP_TEST;
  wire fc = bv && bit_op == `BOP_CLR && acc_addr == `FLAG_PORT && !flag_event;
  wire fw = ds && acc_addr == `FLAG_PORT + `DATA_OFS && !flag_event;
  port_range_a: assert property (pv && acc_addr > `PORT_LAST |=> access_err_reg)
    else $error("port range");
  bit_range_a: assert property (bv && acc_addr > `BIT_LAST |=> access_err_reg && !skip_reg)
    else $error("bit range");
  data_read_a: assert property (dv && !acc_write && acc_addr >= `DATA_OFS |=> rvalid_reg)
    else $error("data read");
  ext_store_a: assert property (ds && acc_addr >= `EXT_FIRST |=> ext_wr_reg
    && ext_addr_reg == $past(acc_addr) && ext_wdata_reg == $past(acc_wdata)) else $error("ext");
  ext_only_a: assert property (ext_wr_reg |-> $past(ds)) else $error("ext src");
  skip_src_a: assert property (skip_reg |-> $past(bt)) else $error("skip src");
  clr_one_a: assert property (fc |=>
    flags_out == ($past(flags_out) & ~(8'h01 << $past(bit_sel)))) else $error("bit clr");
  w1c_a: assert property (fw |=>
    flags_out == ($past(flags_out) & ~$past(acc_wdata))) else $error("w1c");
endmodule
bind io_space_access_decode io_chk i_chk (.*);

// File: ext_mem.sv
// Far-side store for the extended region.
// Assumes decoder store strobe and core address.
`timescale 1ns/1ps
module ext_mem (
  input wire ref_clk,
  input wire wr,
  input wire [8:0] waddr,
  input wire [7:0] wdata,
  input wire [8:0] raddr,
  output wire [7:0] rdata
);
  reg [7:0] mem [0:511];
  // Store on the one-cycle strobe
  always @(posedge ref_clk) begin
    if (wr) begin
      mem[waddr] <= wdata;
    end
  end
  assign rdata = mem[raddr];
endmodule

// File: io_space_access_decode_tb.sv
// Bench for the peripheral space decoder.
// Assumes checker and far-side model compiled first.
`timescale 1ns/1ps
`include "io_decode_consts.vh"
module io_space_access_decode_tb;
  reg ref_clk = 0, reset = 1, v = 0, wr = 0, fe = 0;
  reg [1:0] k = 0, op = 0;
  reg [2:0] sel = 0;
  reg [8:0] a = 0;
  reg [7:0] d = 0, fs = 0;
  wire [7:0] rd, xr, xd, fl;
  wire [8:0] xa;
  wire rv, sk, er, xw;
  integer n_fail = 0, check_count = 0, cyc = 0;
  always #2.5 ref_clk = ~ref_clk;
  io_space_access_decode i_io_space_access_decode (.ref_clk(ref_clk), .reset(reset),
    .acc_valid(v), .acc_kind(k), .acc_write(wr), .acc_addr(a), .acc_wdata(d), .bit_op(op),
    .bit_sel(sel), .flag_event(fe), .flag_set(fs), .ext_rdata(xr), .rdata_reg(rd),
    .rvalid_reg(rv), .skip_reg(sk), .access_err_reg(er), .ext_wr_reg(xw),
    .ext_addr_reg(xa), .ext_wdata_reg(xd), .flags_out(fl));
  ext_mem i_ext_mem (.ref_clk(ref_clk), .wr(xw), .waddr(xa), .wdata(xd), .raddr(a),
    .rdata(xr));
  task chk(input string nm, input [8:0] s, input [8:0] e);
    begin
      check_count = check_count + 1;
      if (s !== e) begin
        n_fail = n_fail + 1;
        $display("MISMATCH %s exp %h got %h", nm, e, s);
      end
    end
  endtask
  // One access, then outputs are settled at the next falling edge
  // Writes go only to assigned locations, never to reserved ones
  // Bytes written carry no reserved bits, so no zero rule is broken
  task acc(input [1:0] kk, input w, input [8:0] aa, input [7:0] dd, input [1:0] o,
    input [2:0] s);
    begin
      @(negedge ref_clk);
      {v, k, wr, a, d, op, sel} = {1'b1, kk, w, aa, dd, o, s};
      @(negedge ref_clk);
      v = 0;
    end
  endtask
  task rchk(input [1:0] kk, input [8:0] aa, input [7:0] e, input string nm);
    begin
      acc(kk, 0, aa, 8'h00, 2'h0, 3'h0);
      chk(nm, rd, e);
    end
  endtask
  task t_store;
    integer i;
    reg [8:0] p;
    begin
      for (i = 0; i < 3; i = i + 1) begin
        p = (i == 0) ? `GS0_PORT : (i == 1) ? `GS1_PORT : `GS2_PORT;
        rchk(`ACC_DATA, p + `DATA_OFS, 8'h00, "gs rst");
        acc(`ACC_PORT, 1, p, 8'h5A + i, 2'h0, 3'h0);
        rchk(`ACC_DATA, p + `DATA_OFS, 8'h5A + i, "gs data");
        acc(`ACC_DATA, 1, p + `DATA_OFS, 8'hC3, 2'h0, 3'h0);
        rchk(`ACC_PORT, p, 8'hC3, "gs port");
      end
      $display("store test done");
    end
  endtask
  task t_bit;
    begin
      acc(`ACC_BIT, 0, `GS0_PORT, 8'h00, `BOP_SET, 3'h5);
      rchk(`ACC_PORT, `GS0_PORT, 8'hE3, "bit set");
      acc(`ACC_BIT, 0, `GS0_PORT, 8'h00, `BOP_TEST, 3'h5);
      chk("skip", sk, 1);
      acc(`ACC_BIT, 0, `GS0_PORT, 8'h00, `BOP_CLR, 3'h5);
      acc(`ACC_BIT, 0, `GS0_PORT, 8'h00, `BOP_TEST, 3'h5);
      chk("noskip", sk, 0);
      acc(`ACC_BIT, 0, `GS1_PORT, 8'h00, `BOP_SET, 3'h0);
      chk("bit err", er, 1);
      rchk(`ACC_PORT, `GS1_PORT, 8'hC3, "bit hi");
      $display("bit test done");
    end
  endtask
  task t_flag;
    begin
      @(negedge ref_clk);
      {fe, fs} = {1'b1, 8'hFF};
      @(negedge ref_clk);
      fe = 0;
      acc(`ACC_BIT, 0, `FLAG_PORT, 8'h00, `BOP_CLR, 3'h2);
      chk("clr", fl, 8'hFB);
      acc(`ACC_BIT, 0, `FLAG_PORT, 8'h00, `BOP_SET, 3'h0);
      chk("set", fl, 8'hFB);
      acc(`ACC_DATA, 1, `FLAG_PORT + `DATA_OFS, 8'h03, 2'h0, 3'h0);
      chk("w1c", fl, 8'hF8);
      $display("flag test done");
    end
  endtask
  task t_ext;
    begin
      acc(`ACC_DATA, 1, 9'h100, 8'h77, 2'h0, 3'h0);
      chk("xaddr", {9{xw}} & xa, 9'h100);
      rchk(`ACC_DATA, 9'h100, 8'h77, "xrd");
      acc(`ACC_PORT, 0, 9'h040, 8'h00, 2'h0, 3'h0);
      chk("port err", er, 1);
      acc(`ACC_DATA, 0, 9'h010, 8'h00, 2'h0, 3'h0);
      chk("data err", er, 1);
      $display("ext test done");
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d fails %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
        $display("DONE - PASS");
      end else begin
        $display("DONE - FAIL");
      end
      $finish;
    end
  endtask
  // Hang guard
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      n_fail = n_fail + 1;
      tally_and_finish;
    end
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    reset = 0;
    t_store;
    t_bit;
    t_flag;
    t_ext;
    tally_and_finish;
  end
endmodule
